//--- hw/secr_regs.sv
// Enable, configuration, pin routing, LED_DRIVER_CONTROL and interrupt enable registers of the sensor front end.
`timescale 1ns/1ns
`include "secr_defines.svh"

module secr_regs (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic mux_done_i,
    input wire logic sync_i,
    input wire logic pd_signal_i,
    input wire logic irq_line_i,
    input wire logic sat_event_i,
    input wire logic spectral_event_i,
    input wire logic fifo_over_thr_i,
    input wire logic flicker_change_i,
    input wire logic aux_pin_i,
    output logic aux_pin_o,
    output logic aux_pin_oe_o,
    output logic irq_pin_o,
    output logic power_on_o,
    output logic osc_enable_o,
    output logic spectral_enable_o,
    output logic wait_enable_o,
    output logic mux_start_o,
    output logic mux_busy_o,
    output logic flicker_enable_o,
    output secr_pkg::secr_mode_t int_mode_o,
    output logic pd_to_aux_o,
    output logic led_driver_pin_o,
    output logic [6:0] led_current_code_o,
    output logic sat_irq_req_o,
    output logic spectral_irq_req_o,
    output logic fifo_irq_req_o,
    output logic system_irq_req_o
);
    import secr_pkg::*;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction : addr_hit

    logic [7:0] en_r;
    logic [7:0] cfg_r;
    logic [7:0] route_r;
    logic [7:0] led_r;
    logic [7:0] aux_r;
    logic [7:0] inten_r;
    logic aux_in_r;
    logic [7:0] en_nxt;
    logic [7:0] cfg_nxt;
    logic [7:0] rd_val;

    wire wr_en = reg_wr_i && addr_hit(reg_addr_i, `SECR_ADDR_EN);
    wire wr_cfg = reg_wr_i && addr_hit(reg_addr_i, `SECR_ADDR_CFG);
    wire wr_route = reg_wr_i && addr_hit(reg_addr_i, `SECR_ADDR_ROUTE);
    wire wr_led = reg_wr_i && addr_hit(reg_addr_i, `SECR_ADDR_LED);
    wire wr_aux = reg_wr_i && addr_hit(reg_addr_i, `SECR_ADDR_AUX);
    wire wr_inten = reg_wr_i && addr_hit(reg_addr_i, `SECR_ADDR_INTEN);

    // ****************************************************************
    // Next values
    // ****************************************************************
    // A host write of one beats a completion in the same cycle and keeps the bit set, but gives no mux_start_o pulse, as that needs the bit clear before.
    wire mux_bit_nxt = wr_en ? reg_wdata_i[`SECR_EN_MUX] : (en_r[`SECR_EN_MUX] & ~mux_done_i);
    wire [7:0] en_w = reg_wdata_i & `SECR_MASK_EN;
    wire [7:0] en_base = wr_en ? en_w : en_r;

    always_comb begin
        en_nxt = en_base;
        en_nxt[`SECR_EN_MUX] = mux_bit_nxt;
    end

    // A reserved mode code leaves the previous mode in force, so the engine never sees it.
    wire mode_rsvd = (reg_wdata_i[1:0] == `SECR_MODE_RSVD);
    wire [1:0] mode_nxt = (wr_cfg && !mode_rsvd) ? reg_wdata_i[1:0] : cfg_r[1:0];
    wire [1:0] cfg_hi_nxt = wr_cfg ? reg_wdata_i[`SECR_CFG_LEDSEL:`SECR_CFG_SYNC] :
        cfg_r[`SECR_CFG_LEDSEL:`SECR_CFG_SYNC];

    always_comb begin
        cfg_nxt = `SECR_RST_ZERO;
        cfg_nxt[1:0] = mode_nxt;
        cfg_nxt[`SECR_CFG_LEDSEL:`SECR_CFG_SYNC] = cfg_hi_nxt;
    end

    wire [7:0] route_nxt = wr_route ? (reg_wdata_i & `SECR_MASK_ROUTE) : route_r;
    wire [7:0] led_nxt = wr_led ? (reg_wdata_i & `SECR_MASK_LED) : led_r;
    wire [7:0] aux_nxt = wr_aux ? (reg_wdata_i & `SECR_MASK_AUX) : aux_r;
    wire [7:0] inten_nxt = wr_inten ? (reg_wdata_i & `SECR_MASK_INTEN) : inten_r;

    // The pin is only sampled while it is an input, so a driven level never reads back.
    wire aux_in_nxt = aux_r[`SECR_AUX_INEN] & aux_pin_i;

    // ****************************************************************
    // Pin and output values
    // ****************************************************************
    wire power_nxt = en_nxt[`SECR_EN_PON];
    wire spec_nxt = en_nxt[`SECR_EN_SPEN];
    wire wait_nxt = en_nxt[`SECR_EN_WAIT];
    wire fd_nxt = en_nxt[`SECR_EN_FD];
    wire mux_start_nxt = wr_en && reg_wdata_i[`SECR_EN_MUX] && !en_r[`SECR_EN_MUX];
    wire pd_irq_nxt = route_nxt[`SECR_ROUTE_IRQ];
    wire pd_aux_nxt = route_nxt[`SECR_ROUTE_AUX];
    wire irq_pin_nxt = cfg_nxt[`SECR_CFG_SYNC] ? sync_i :
        (pd_irq_nxt ? pd_signal_i : irq_line_i);
    wire led_pin_nxt = cfg_nxt[`SECR_CFG_LEDSEL] & led_nxt[`SECR_LED_ON];
    wire aux_out_nxt = aux_nxt[`SECR_AUX_OUT] ^ aux_nxt[`SECR_AUX_INV];
    // The pin is released while it is an input or carries a photodiode, so nothing fights it.
    wire aux_oe_nxt = ~aux_nxt[`SECR_AUX_INEN] & ~pd_aux_nxt;
    wire sat_req_nxt = inten_r[`SECR_IE_SAT] & sat_event_i;
    wire spec_req_nxt = inten_r[`SECR_IE_SPEC] & spectral_event_i;
    wire fifo_req_nxt = inten_r[`SECR_IE_FIFO] & fifo_over_thr_i;
    wire sys_req_nxt = inten_r[`SECR_IE_SYS] & (flicker_change_i | mux_done_i);

    // ****************************************************************
    // Read decoding
    // ****************************************************************
    always_comb begin
        rd_val = `SECR_RST_ZERO;
        if (addr_hit(reg_addr_i, `SECR_ADDR_EN)) begin
            rd_val = en_r;
            rd_val[`SECR_EN_MIRROR] = inten_r[`SECR_IE_SPEC];
        end else if (addr_hit(reg_addr_i, `SECR_ADDR_CFG)) begin
            rd_val = cfg_r;
        end else if (addr_hit(reg_addr_i, `SECR_ADDR_ROUTE)) begin
            rd_val = route_r;
        end else if (addr_hit(reg_addr_i, `SECR_ADDR_LED)) begin
            rd_val = led_r;
        end else if (addr_hit(reg_addr_i, `SECR_ADDR_AUX)) begin
            rd_val = aux_r;
            rd_val[`SECR_AUX_IN] = aux_in_r;
        end else if (addr_hit(reg_addr_i, `SECR_ADDR_INTEN)) begin
            rd_val = inten_r;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_r <= `SECR_RST_ZERO;
            cfg_r <= `SECR_RST_ZERO;
            route_r <= `SECR_RST_ZERO;
            led_r <= `SECR_RST_LED;
            aux_r <= `SECR_RST_AUX;
            inten_r <= `SECR_RST_ZERO;
            aux_in_r <= 1'b0;
        end else begin
            en_r <= en_nxt;
            cfg_r <= cfg_nxt;
            route_r <= route_nxt;
            led_r <= led_nxt;
            aux_r <= aux_nxt;
            inten_r <= inten_nxt;
            aux_in_r <= aux_in_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= `SECR_RST_ZERO;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_val;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            power_on_o <= 1'b0;
            osc_enable_o <= 1'b0;
            spectral_enable_o <= 1'b0;
            wait_enable_o <= 1'b0;
            mux_start_o <= 1'b0;
            mux_busy_o <= 1'b0;
            flicker_enable_o <= 1'b0;
            int_mode_o <= SECR_NORMAL_SPECTRAL_MODE;
        end else begin
            power_on_o <= power_nxt;
            osc_enable_o <= power_nxt;
            spectral_enable_o <= spec_nxt;
            wait_enable_o <= wait_nxt;
            mux_start_o <= mux_start_nxt;
            mux_busy_o <= en_nxt[`SECR_EN_MUX];
            flicker_enable_o <= fd_nxt;
            int_mode_o <= secr_mode_t'(mode_nxt);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aux_pin_o <= 1'b1;
            aux_pin_oe_o <= 1'b1;
            irq_pin_o <= 1'b0;
            pd_to_aux_o <= 1'b0;
            led_driver_pin_o <= 1'b0;
            led_current_code_o <= 7'(`SECR_RST_LED);
        end else begin
            aux_pin_o <= aux_out_nxt;
            aux_pin_oe_o <= aux_oe_nxt;
            irq_pin_o <= irq_pin_nxt;
            pd_to_aux_o <= pd_aux_nxt;
            led_driver_pin_o <= led_pin_nxt;
            led_current_code_o <= led_nxt[6:0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sat_irq_req_o <= 1'b0;
            spectral_irq_req_o <= 1'b0;
            fifo_irq_req_o <= 1'b0;
            system_irq_req_o <= 1'b0;
        end else begin
            sat_irq_req_o <= sat_req_nxt;
            spectral_irq_req_o <= spec_req_nxt;
            fifo_irq_req_o <= fifo_req_nxt;
            system_irq_req_o <= sys_req_nxt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_mux_cmd;
        wr_en && reg_wdata_i[`SECR_EN_MUX] && !mux_busy_o;
    endsequence

    sequence s_mux_pulse;
        mux_start_o && mux_busy_o ##1 !mux_start_o;
    endsequence

    property p_pon;
        wr_en |=> power_on_o == $past(reg_wdata_i[0]) && osc_enable_o == power_on_o;
    endproperty
    a_pon: assert property (p_pon) else $error("power bit not applied");

    property p_spen;
        wr_en |=> spectral_enable_o == $past(reg_wdata_i[1]);
    endproperty
    a_spen: assert property (p_spen) else $error("spectral enable not applied");

    property p_wait;
        wr_en |=> wait_enable_o == $past(reg_wdata_i[3]);
    endproperty
    a_wait: assert property (p_wait) else $error("wait enable not applied");

    property p_mux_start;
        s_mux_cmd |=> s_mux_pulse;
    endproperty
    a_mux_start: assert property (p_mux_start) else $error("mux start pulse wrong");

    property p_mux_clear;
        mux_busy_o && mux_done_i && !wr_en |=> !mux_busy_o;
    endproperty
    a_mux_clear: assert property (p_mux_clear) else $error("mux bit not cleared");

    property p_fd;
        wr_en |=> flicker_enable_o == $past(reg_wdata_i[6]);
    endproperty
    a_fd: assert property (p_fd) else $error("flicker enable not applied");

    property p_mode_rsvd;
        wr_cfg && mode_rsvd |=> $stable(int_mode_o);
    endproperty
    a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode taken");

    property p_sync;
        cfg_r[2] |-> irq_pin_o == $past(sync_i);
    endproperty
    a_sync: assert property (p_sync) else $error("sync not on interrupt pin");

    property p_led_off;
        !cfg_r[3] |-> !led_driver_pin_o;
    endproperty
    a_led_off: assert property (p_led_off) else $error("LED_DRIVER_CONTROL driven without ownership");

    property p_led_on;
        cfg_r[3] && led_r[7] |-> led_driver_pin_o;
    endproperty
    a_led_on: assert property (p_led_on) else $error("LED_DRIVER_CONTROL not lit");

    property p_aux_out;
        aux_pin_oe_o |-> aux_pin_o == (aux_r[1] ^ aux_r[3]);
    endproperty
    a_aux_out: assert property (p_aux_out) else $error("aux output level wrong");

    property p_aux_in;
        aux_r[2] |=> aux_in_r == $past(aux_pin_i);
    endproperty
    a_aux_in: assert property (p_aux_in) else $error("aux input not sampled");

    property p_fifo_irq;
        fifo_irq_req_o == $past(inten_r[2] && fifo_over_thr_i);
    endproperty
    a_fifo_irq: assert property (p_fifo_irq) else $error("fifo request gating wrong");

    property p_sys_irq;
        system_irq_req_o == $past(inten_r[`SECR_IE_SYS] && (flicker_change_i || mux_done_i));
    endproperty
    a_sys_irq: assert property (p_sys_irq) else $error("system request wrong");

    property p_pd_route;
        route_r[`SECR_ROUTE_AUX] |-> pd_to_aux_o && !aux_pin_oe_o;
    endproperty
    a_pd_route: assert property (p_pd_route) else $error("aux route wrong");

    property p_rsvd;
        reg_rd_i && addr_hit(reg_addr_i, `SECR_ADDR_CFG) |=> reg_rdata_o[7:4] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

endmodule : secr_regs

//--- hw/secr_defines.svh
// Register offsets, field positions, masks and reset values of the enable, config, routing, LED, aux and interrupt enable registers.
`ifndef SECR_DEFINES_SVH
`define SECR_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SECR_ADDR_CFG 8'h70
`define SECR_ADDR_ROUTE 8'h73
`define SECR_ADDR_LED 8'h74
`define SECR_ADDR_EN 8'h80
`define SECR_ADDR_AUX 8'hBE
`define SECR_ADDR_INTEN 8'hF9

// ****************************************************************
// Field positions
// ****************************************************************
`define SECR_EN_PON 0
`define SECR_EN_SPEN 1
`define SECR_EN_MIRROR 2
`define SECR_EN_WAIT 3
`define SECR_EN_MUX 4
`define SECR_EN_FD 6
`define SECR_CFG_SYNC 2
`define SECR_CFG_LEDSEL 3
`define SECR_ROUTE_IRQ 0
`define SECR_ROUTE_AUX 1
`define SECR_LED_ON 7
`define SECR_AUX_IN 0
`define SECR_AUX_OUT 1
`define SECR_AUX_INEN 2
`define SECR_AUX_INV 3
`define SECR_IE_SYS 0
`define SECR_IE_FIFO 2
`define SECR_IE_SPEC 3
`define SECR_IE_SAT 7

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define SECR_MASK_EN 8'h5B
`define SECR_MASK_CFG 8'h0F
`define SECR_MASK_ROUTE 8'h03
`define SECR_MASK_LED 8'hFF
`define SECR_MASK_AUX 8'h0E
`define SECR_MASK_INTEN 8'h8D
`define SECR_RST_ZERO 8'h00
`define SECR_RST_LED 8'h04
`define SECR_RST_AUX 8'h02
`define SECR_MODE_RSVD 2'b10

`endif

//--- hw/secr_pkg.sv
// Types shared by the enable and configuration register block.
package secr_pkg;

    typedef enum logic [1:0] {
        SECR_NORMAL_SPECTRAL_MODE = 2'b00,
        SECR_SYNC_START_MODE = 2'b01,
        SECR_MODE_RESERVED = 2'b10,
        SECR_SYNC_START_STOP_MODE = 2'b11
    } secr_mode_t;

endpackage : secr_pkg

//--- tb/secr_host.sv
// Host model that drives the byte strobe register port of the register block.
`timescale 1ns/1ns
`include "secr_defines.svh"

module secr_host (
    input wire logic clk_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // ****************************************************************
    // Register cycles
    // ****************************************************************
    // Address and data are inverted on release, so late latching sees a wrong value.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask : write_reg

    // Reads touch control registers and the unmapped offset 8'h71, never the result data ranges.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_i);
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        data = reg_rdata_i;
    endtask : read_reg

    // Configuration is only written here before spectral enable is raised.
    task automatic start_measure(input logic [7:0] cfg, input logic [7:0] inten);
        write_reg(`SECR_ADDR_EN, 8'h01);
        write_reg(`SECR_ADDR_CFG, cfg);
        write_reg(`SECR_ADDR_INTEN, inten);
        write_reg(`SECR_ADDR_EN, 8'h03);
    endtask : start_measure
endmodule : secr_host

//--- tb/testbench.sv
// Self-checking testbench of the enable and configuration register block.
`timescale 1ns/1ns
`include "secr_defines.svh"

module testbench;
    import secr_pkg::*;
    logic clk_i, nrst_i, reg_wr_i, reg_rd_i, mux_done_i, sync_i, pd_signal_i, irq_line_i;
    logic sat_event_i, spectral_event_i, fifo_over_thr_i, flicker_change_i, aux_pin_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
    logic aux_pin_o, aux_pin_oe_o, irq_pin_o, power_on_o, osc_enable_o, spectral_enable_o;
    logic wait_enable_o, mux_start_o, mux_busy_o, flicker_enable_o, pd_to_aux_o;
    logic led_driver_pin_o, sat_irq_req_o, spectral_irq_req_o, fifo_irq_req_o, system_irq_req_o;
    logic [6:0] led_current_code_o;
    secr_mode_t int_mode_o;
    int fails = 0;
    int check_count = 0;

    secr_host host_u (.clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
    secr_regs dut_u (.clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .mux_done_i, .sync_i, .pd_signal_i, .irq_line_i, .sat_event_i,
        .spectral_event_i, .fifo_over_thr_i, .flicker_change_i, .aux_pin_i, .aux_pin_o,
        .aux_pin_oe_o, .irq_pin_o, .power_on_o, .osc_enable_o, .spectral_enable_o,
        .wait_enable_o, .mux_start_o, .mux_busy_o, .flicker_enable_o, .int_mode_o,
        .pd_to_aux_o, .led_driver_pin_o, .led_current_code_o, .sat_irq_req_o,
        .spectral_irq_req_o, .fifo_irq_req_o, .system_irq_req_o);

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic rchk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        host_u.read_reg(addr, rd_v);
        chk(name, rd_v, exp);
    endtask : rchk

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        host_u.write_reg(addr, data);
    endtask : wr

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk("aux_out", {7'h00, aux_pin_o}, 8'h01);
        chk("aux_oe", {7'h00, aux_pin_oe_o}, 8'h01);
        chk("led_code", {1'b0, led_current_code_o}, 8'h04);
        rchk("en", `SECR_ADDR_EN, 8'h00);
        rchk("cfg", `SECR_ADDR_CFG, 8'h00);
        rchk("route", `SECR_ADDR_ROUTE, 8'h00);
        rchk("led", `SECR_ADDR_LED, 8'h04);
        rchk("aux", `SECR_ADDR_AUX, 8'h02);
        rchk("inten", `SECR_ADDR_INTEN, 8'h00);
    endtask : t_reset

    task automatic t_enable();
        host_u.start_measure(8'h00, 8'h09);
        chk("pwr", {7'h00, power_on_o}, 8'h01);
        chk("osc", {7'h00, osc_enable_o}, 8'h01);
        chk("spen", {7'h00, spectral_enable_o}, 8'h01);
        wr(`SECR_ADDR_EN, 8'hFF);
        chk("wen", {7'h00, wait_enable_o}, 8'h01);
        chk("flicker_detect_enable", {7'h00, flicker_enable_o}, 8'h01);
        chk("mstart", {7'h00, mux_start_o}, 8'h01);
        chk("mbusy", {7'h00, mux_busy_o}, 8'h01);
        rchk("en", `SECR_ADDR_EN, 8'h5F);
        chk("mstart", {7'h00, mux_start_o}, 8'h00);
        mux_done_i = 1'b1;
        @(negedge clk_i);
        mux_done_i = 1'b0;
        chk("mbusy", {7'h00, mux_busy_o}, 8'h00);
        chk("sysirq", {7'h00, system_irq_req_o}, 8'h01);
        rchk("en", `SECR_ADDR_EN, 8'h4F);
        wr(`SECR_ADDR_EN, 8'h00);
        chk("pwr", {7'h00, power_on_o}, 8'h00);
        chk("osc", {7'h00, osc_enable_o}, 8'h00);
        chk("spen", {7'h00, spectral_enable_o}, 8'h00);
        chk("flicker_detect_enable", {7'h00, flicker_enable_o}, 8'h00);
        rchk("en", `SECR_ADDR_EN, 8'h04);
    endtask : t_enable

    task automatic t_mode();
        logic [1:0] modes [3] = '{2'b00, 2'b01, 2'b11};
        foreach (modes[i]) begin
            wr(`SECR_ADDR_CFG, {6'h00, modes[i]});
            chk("mode", {6'h00, int_mode_o}, {6'h00, modes[i]});
        end
        wr(`SECR_ADDR_CFG, 8'hF6);
        chk("mode", {6'h00, int_mode_o}, 8'h03);
        rchk("cfg", `SECR_ADDR_CFG, 8'h07);
    endtask : t_mode

    task automatic t_irq_pin();
        sync_i = 1'b1;
        @(negedge clk_i);
        chk("irqpin", {7'h00, irq_pin_o}, 8'h01);
        wr(`SECR_ADDR_CFG, 8'h03);
        wr(`SECR_ADDR_ROUTE, 8'hFD);
        pd_signal_i = 1'b1;
        @(negedge clk_i);
        chk("irqpin", {7'h00, irq_pin_o}, 8'h01);
        pd_signal_i = 1'b0;
        irq_line_i = 1'b1;
        @(negedge clk_i);
        chk("irqpin", {7'h00, irq_pin_o}, 8'h00);
        rchk("route", `SECR_ADDR_ROUTE, 8'h01);
        wr(`SECR_ADDR_ROUTE, 8'h02);
        chk("irqpin", {7'h00, irq_pin_o}, 8'h01);
        chk("pdaux", {7'h00, pd_to_aux_o}, 8'h01);
        chk("aux_oe", {7'h00, aux_pin_oe_o}, 8'h00);
        wr(`SECR_ADDR_ROUTE, 8'h00);
    endtask : t_irq_pin

    task automatic t_led();
        wr(`SECR_ADDR_LED, 8'hFF);
        chk("ledpin", {7'h00, led_driver_pin_o}, 8'h00);
        chk("led_code", {1'b0, led_current_code_o}, 8'h7F);
        wr(`SECR_ADDR_CFG, 8'h08);
        chk("ledpin", {7'h00, led_driver_pin_o}, 8'h01);
        wr(`SECR_ADDR_LED, 8'h00);
        chk("ledpin", {7'h00, led_driver_pin_o}, 8'h00);
        chk("led_code", {1'b0, led_current_code_o}, 8'h00);
    endtask : t_led

    task automatic t_aux();
        wr(`SECR_ADDR_AUX, 8'h08);
        chk("aux_out", {7'h00, aux_pin_o}, 8'h01);
        wr(`SECR_ADDR_AUX, 8'h0A);
        chk("aux_out", {7'h00, aux_pin_o}, 8'h00);
        wr(`SECR_ADDR_AUX, 8'h02);
        chk("aux_out", {7'h00, aux_pin_o}, 8'h01);
        aux_pin_i = 1'b1;
        wr(`SECR_ADDR_AUX, 8'hF5);
        chk("aux_oe", {7'h00, aux_pin_oe_o}, 8'h00);
        rchk("aux", `SECR_ADDR_AUX, 8'h05);
        aux_pin_i = 1'b0;
        rchk("aux", `SECR_ADDR_AUX, 8'h04);
    endtask : t_aux

    task automatic t_irq_req();
        logic [7:0] masks [6] = '{8'h80, 8'h08, 8'h04, 8'h01, 8'h00, 8'hFF};
        logic [7:0] exps [6] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h00, 8'h0F};
        foreach (masks[i]) begin
            wr(`SECR_ADDR_INTEN, masks[i]);
            {sat_event_i, spectral_event_i, fifo_over_thr_i, flicker_change_i} = 4'hF;
            @(negedge clk_i);
            chk("irqreq", {4'h0, sat_irq_req_o, spectral_irq_req_o, fifo_irq_req_o,
                system_irq_req_o}, exps[i]);
            {sat_event_i, spectral_event_i, fifo_over_thr_i, flicker_change_i} = 4'h0;
        end
        rchk("inten", `SECR_ADDR_INTEN, 8'h8D);
        wr(8'h71, 8'hFF);
        rchk("unmap", 8'h71, 8'h00);
        rchk("cfg", `SECR_ADDR_CFG, 8'h08);
    endtask : t_irq_req

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial begin
        {nrst_i, mux_done_i, sync_i, pd_signal_i, irq_line_i, aux_pin_i} = 6'h00;
        {sat_event_i, spectral_event_i, fifo_over_thr_i, flicker_change_i} = 4'h0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        nrst_i = 1'b1;
        t_reset();
        t_enable();
        t_mode();
        t_irq_pin();
        t_led();
        t_aux();
        t_irq_req();
        results();
    end

    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        results();
    end
endmodule : testbench
